// File: ppmc_consts.svh
// ppmc_consts.svh: register indices, bit positions, reset values, timing
// assumes a 25 MHz aclk; indices are word numbers, byte address = 4 x index
`ifndef PPMC_CONSTS_SVH
`define PPMC_CONSTS_SVH

`define PPMC_IDX_BCTL      6'h00
`define PPMC_IDX_DRC       6'h10
`define PPMC_IDX_AFE       6'h11
`define PPMC_IDX_XCTL      6'h18
`define PPMC_IDX_OWN       6'h1C
`define PPMC_IDX_PCTL2     6'h1F

`define PPMC_B_SRST        15
`define PPMC_B_ANEN        12
`define PPMC_B_PDN         11
`define PPMC_B_PLLOFF      4
`define PPMC_B_SLOW        5
`define PPMC_B_SENSE_N     11
`define PPMC_B_PSAVE       10
`define PPMC_B_LONGGAP     0
`define PPMC_B_STATE       4
`define PPMC_B_PWR         9

`define PPMC_RST_ANEN      1'h1
`define PPMC_RST_PDN       1'h0
`define PPMC_RST_PLLOFF    1'h0
`define PPMC_RST_SLOW      1'h0
`define PPMC_RST_SENSE_N   1'h1
`define PPMC_RST_PSAVE     1'h0
`define PPMC_RST_LONGGAP   1'h0

`define PPMC_CLK_MHZ       25
`define PPMC_GAP_SHORT_US  16000
`define PPMC_GAP_LONG_US   64000
`define PPMC_WAKE_US       2000

`define PPMC_RESP_OKAY     2'h0
`define PPMC_RESP_SLVERR   2'h2

`endif

// File: ppmc_pkg.sv
// ppmc_pkg: state, power-enable and control types of the power controller
// assumes ppmc_consts.svh sits in the include path
`include "ppmc_consts.svh"
package ppmc_pkg;

	typedef enum logic [4:0] {
		ST_NORMAL = 5'h01,
		ST_PSAVE  = 5'h02,
		ST_SLEEP  = 5'h04,
		ST_WAKE   = 5'h08,
		ST_PDOWN  = 5'h10
	} ppmc_state_t;

	typedef struct packed {
		logic core_on;
		logic rx_on;
		logic pll_on;
		logic ed_on;
		logic tx_on;
	} ppmc_pwr_t;

	typedef struct packed {
		logic an_en;
		logic pdn;
		logic plloff;
		logic slow;
		logic sense_n;
		logic psave;
		logic long_gap;
	} ppmc_ctl_t;

	localparam ppmc_ctl_t PPMC_CTL_RST = '{
		an_en:    `PPMC_RST_ANEN,
		pdn:      `PPMC_RST_PDN,
		plloff:   `PPMC_RST_PLLOFF,
		slow:     `PPMC_RST_SLOW,
		sense_n:  `PPMC_RST_SENSE_N,
		psave:    `PPMC_RST_PSAVE,
		long_gap: `PPMC_RST_LONGGAP
	};

endpackage : ppmc_pkg

// File: ppmc_pulse_timer.sv
// ppmc_pulse_timer: periodic link-pulse strobe while sleeping on the cable
// assumes run is a registered level from the controller
`timescale 1ns/100ps
module ppmc_pulse_timer #(
	parameter int unsigned SHORT_CYC = 400000,
	parameter int unsigned LONG_CYC  = 1600000,
	parameter int unsigned CNT_W     = 24
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic run,
	input  wire logic long_gap,
	// strobe
	output logic      link_pulse
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] limit;
	logic             hit;

	// gap may shrink mid-count, so compare with >= and not ==
	assign limit = long_gap ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
	assign hit   = run && (cnt_q >= limit);
	assign cnt_d = (!run || hit) ? '0 : cnt_q + CNT_W'(1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q      <= '0;
			link_pulse <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			link_pulse <= hit;
		end
	end

endmodule : ppmc_pulse_timer

// File: ppmc_power_ctl.sv
// ppmc_power_ctl: low-power mode controller with an AXI4-Lite register port
// assumes link_up and energy_detect are synchronous to aclk
// How it works
// - setting the power-saving bit in register 1Fh enables power saving, clear keeps it off.
// - power saving acts only with auto-negotiation on and no link, else normal operation.
// - in power saving only core, transmitter, energy detect and PLL stay powered.
// - power saving comes up disabled after reset.
// - clearing the active-low bit 11 of 18h enables sense sleep, only with autoneg on and no link.
// - with bit 4 of 10h set the PLL is switched off during sense sleep.
// - link pulses keep going out during sense sleep, with an optional longer gap.
// - the active-low sense sleep enable resets to its inactive value.
// - bit 11 of register 0h halts everything but the register interface.
// - clearing bit 11 of register 0h leaves power-down.
// - bit 5 of 11h drops the crystal input and selects the slow oscillator.
// - slow oscillator together with power-down is the lowest power state.
`timescale 1ns/100ps
`include "ppmc_consts.svh"
module ppmc_power_ctl #(
	parameter int unsigned GAP_SHORT_CYC = `PPMC_GAP_SHORT_US * `PPMC_CLK_MHZ,
	parameter int unsigned GAP_LONG_CYC  = `PPMC_GAP_LONG_US * `PPMC_CLK_MHZ,
	parameter int unsigned WAKE_CYC      = `PPMC_WAKE_US * `PPMC_CLK_MHZ,
	parameter int unsigned CNT_W         = 24,
	parameter int unsigned ADDR_W        = 8
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// axi4-lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// line status
	input  wire logic                 link_up,
	input  wire logic                 energy_detect,
	// power and clock steering
	output ppmc_pkg::ppmc_pwr_t       pwr,
	output logic                      crystal_input_en,
	output logic                      slow_osc_sel,
	output logic                      lowest_power,
	output logic                      link_pulse,
	output logic                      soft_reset
);

	function automatic logic hit(input logic [ADDR_W-1:0] a);
		logic [5:0] i;
		i = a[7:2];
		return (i == `PPMC_IDX_BCTL) || (i == `PPMC_IDX_DRC) ||
		       (i == `PPMC_IDX_AFE) || (i == `PPMC_IDX_XCTL) ||
		       (i == `PPMC_IDX_OWN) || (i == `PPMC_IDX_PCTL2);
	endfunction : hit

	function automatic logic upd(input logic sel, input logic [3:0] strb,
	                             input logic [31:0] d, input int unsigned b,
	                             input logic old);
		return (sel && strb[b / 8]) ? d[b] : old;
	endfunction : upd

	function automatic logic [31:0] fld(input logic [15:0] v, input int unsigned b);
		return 32'(v) << b;
	endfunction : fld

	// write and read channel holding
	logic [ADDR_W-1:0]     aw_addr_q;
	logic                  aw_full_q;
	logic [31:0]           w_data_q;
	logic [3:0]            w_strb_q;
	logic                  w_full_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	logic [31:0]           rdata_q;
	logic [31:0]           rd_word;

	// control and state
	ppmc_pkg::ppmc_ctl_t   ctl_q;
	ppmc_pkg::ppmc_ctl_t   ctl_d;
	ppmc_pkg::ppmc_state_t state_q;
	ppmc_pkg::ppmc_state_t state_d;
	ppmc_pkg::ppmc_state_t base;
	ppmc_pkg::ppmc_pwr_t   pwr_d;
	logic [CNT_W-1:0]      wake_cnt_q;
	logic                  srst_q;

	logic                  aw_take;
	logic                  w_take;
	logic                  ar_take;
	logic                  wr_go;
	logic [5:0]            aw_idx;
	logic [5:0]            ar_idx;
	logic                  wr_bctl;
	logic                  wr_drc;
	logic                  wr_afe;
	logic                  wr_xctl;
	logic                  wr_own;
	logic                  wr_pctl2;
	logic                  srst;
	logic                  sleep_ok;
	logic                  psave_ok;
	logic                  wake_done;

	// bus handshakes: one write and one read in flight at most
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready  = !w_full_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign wr_go         = aw_full_q && w_full_q;
	assign aw_idx        = aw_addr_q[7:2];
	assign ar_idx        = s_axi_araddr[7:2];
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	// register write decode
	assign wr_bctl  = wr_go && (aw_idx == `PPMC_IDX_BCTL);
	assign wr_drc   = wr_go && (aw_idx == `PPMC_IDX_DRC);
	assign wr_afe   = wr_go && (aw_idx == `PPMC_IDX_AFE);
	assign wr_xctl  = wr_go && (aw_idx == `PPMC_IDX_XCTL);
	assign wr_own   = wr_go && (aw_idx == `PPMC_IDX_OWN);
	assign wr_pctl2 = wr_go && (aw_idx == `PPMC_IDX_PCTL2);
	// self-clearing soft reset; wins over the other bits of the same write
	assign srst     = upd(wr_bctl, w_strb_q, w_data_q, `PPMC_B_SRST, 1'b0);

	assign ctl_d.an_en    = upd(wr_bctl, w_strb_q, w_data_q, `PPMC_B_ANEN, ctl_q.an_en);
	assign ctl_d.pdn      = upd(wr_bctl, w_strb_q, w_data_q, `PPMC_B_PDN, ctl_q.pdn);
	assign ctl_d.plloff   = upd(wr_drc, w_strb_q, w_data_q, `PPMC_B_PLLOFF, ctl_q.plloff);
	assign ctl_d.slow     = upd(wr_afe, w_strb_q, w_data_q, `PPMC_B_SLOW, ctl_q.slow);
	assign ctl_d.sense_n  = upd(wr_xctl, w_strb_q, w_data_q, `PPMC_B_SENSE_N, ctl_q.sense_n);
	assign ctl_d.psave    = upd(wr_pctl2, w_strb_q, w_data_q, `PPMC_B_PSAVE, ctl_q.psave);
	assign ctl_d.long_gap = upd(wr_own, w_strb_q, w_data_q, `PPMC_B_LONGGAP, ctl_q.long_gap);

	// read mux; soft reset bit always reads zero
	assign rd_word =
		(ar_idx == `PPMC_IDX_BCTL)  ? (fld(16'(ctl_q.an_en), `PPMC_B_ANEN) |
		                               fld(16'(ctl_q.pdn), `PPMC_B_PDN)) :
		(ar_idx == `PPMC_IDX_DRC)   ? fld(16'(ctl_q.plloff), `PPMC_B_PLLOFF) :
		(ar_idx == `PPMC_IDX_AFE)   ? fld(16'(ctl_q.slow), `PPMC_B_SLOW) :
		(ar_idx == `PPMC_IDX_XCTL)  ? fld(16'(ctl_q.sense_n), `PPMC_B_SENSE_N) :
		(ar_idx == `PPMC_IDX_PCTL2) ? fld(16'(ctl_q.psave), `PPMC_B_PSAVE) :
		(ar_idx == `PPMC_IDX_OWN)   ? (fld(16'(ctl_q.long_gap), `PPMC_B_LONGGAP) |
		                               fld(16'(state_q), `PPMC_B_STATE) |
		                               fld(16'(pwr), `PPMC_B_PWR)) :
		32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q <= '0;
			aw_full_q <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `PPMC_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_q <= s_axi_awaddr;
				aw_full_q <= 1'b1;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= hit(aw_addr_q) ? `PPMC_RESP_OKAY : `PPMC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= `PPMC_RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= hit(s_axi_araddr) ? `PPMC_RESP_OKAY : `PPMC_RESP_SLVERR;
			rdata_q  <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// mode bits: power saving off, sense sleep off after reset
	always_ff @(posedge aclk) begin
		if (!aresetn || srst) begin
			ctl_q <= ppmc_pkg::PPMC_CTL_RST;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// mode selection; power-down outranks sense sleep outranks power saving
	assign sleep_ok  = !ctl_q.sense_n && ctl_q.an_en && !link_up;
	assign psave_ok  = ctl_q.psave && ctl_q.an_en && !link_up;
	assign wake_done = (wake_cnt_q == CNT_W'(WAKE_CYC - 1));
	assign base = ctl_q.pdn ? ppmc_pkg::ST_PDOWN :
	              sleep_ok  ? ppmc_pkg::ST_SLEEP :
	              psave_ok  ? ppmc_pkg::ST_PSAVE : ppmc_pkg::ST_NORMAL;

	always_comb begin
		state_d = base;
		if (srst) begin
			state_d = ppmc_pkg::ST_NORMAL;
		end else begin
			unique case (state_q)
				ppmc_pkg::ST_NORMAL,
				ppmc_pkg::ST_PSAVE,
				ppmc_pkg::ST_PDOWN: state_d = base;
				ppmc_pkg::ST_SLEEP: begin
					if (base == ppmc_pkg::ST_SLEEP && energy_detect) begin
						state_d = ppmc_pkg::ST_WAKE;
					end
				end
				ppmc_pkg::ST_WAKE: begin
					// stay up to seek a link; drop back if none shows in time
					if (base == ppmc_pkg::ST_SLEEP && !wake_done) begin
						state_d = ppmc_pkg::ST_WAKE;
					end
				end
				default: state_d = ppmc_pkg::ST_NORMAL;
			endcase
		end
	end

	// power enables follow the next state so they line up with state_q
	assign pwr_d =
		(state_d == ppmc_pkg::ST_PDOWN) ? ppmc_pkg::ppmc_pwr_t'(5'h00) :
		(state_d == ppmc_pkg::ST_SLEEP) ?
			ppmc_pkg::ppmc_pwr_t'{core_on: 1'b1, rx_on: 1'b0, pll_on: !ctl_d.plloff,
			  ed_on: 1'b1, tx_on: 1'b1} :
		(state_d == ppmc_pkg::ST_PSAVE) ?
			ppmc_pkg::ppmc_pwr_t'{core_on: 1'b1, rx_on: 1'b0, pll_on: 1'b1,
			  ed_on: 1'b1, tx_on: 1'b1} :
		ppmc_pkg::ppmc_pwr_t'(5'h1F);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= ppmc_pkg::ST_NORMAL;
			pwr        <= ppmc_pkg::ppmc_pwr_t'(5'h1F);
			wake_cnt_q <= '0;
			srst_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			pwr        <= pwr_d;
			wake_cnt_q <= (state_q == ppmc_pkg::ST_WAKE && !wake_done) ?
			              wake_cnt_q + CNT_W'(1) : '0;
			srst_q     <= srst;
		end
	end

	// clock steering follows the slow-oscillator bit directly
	assign slow_osc_sel     = ctl_q.slow;
	assign crystal_input_en = !ctl_q.slow;
	assign lowest_power     = ctl_q.slow && (state_q == ppmc_pkg::ST_PDOWN);
	assign soft_reset       = srst_q;

	// pulses only while asleep so two sleeping ends still find each other
	ppmc_pulse_timer #(
		.SHORT_CYC (GAP_SHORT_CYC),
		.LONG_CYC  (GAP_LONG_CYC),
		.CNT_W     (CNT_W)
	) u_pulse (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.run        (state_q == ppmc_pkg::ST_SLEEP),
		.long_gap   (ctl_q.long_gap),
		.link_pulse (link_pulse)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sleep_energy;
		state_q == ppmc_pkg::ST_SLEEP && energy_detect && !ctl_q.pdn && sleep_ok;
	endsequence

	sequence s_all_up;
		state_q == ppmc_pkg::ST_WAKE ##0 pwr.pll_on && pwr.rx_on && pwr.core_on;
	endsequence

	sequence s_pdn_cleared;
		state_q == ppmc_pkg::ST_PDOWN && !ctl_q.pdn;
	endsequence

	a_psave_write_on: assert property (
		wr_pctl2 && w_strb_q[1] && w_data_q[`PPMC_B_PSAVE] && !srst |=> ctl_q.psave)
		else $error("power saving bit not stored");

	a_psave_gated: assert property (
		$rose(state_q == ppmc_pkg::ST_PSAVE) |->
		$past(ctl_q.psave && ctl_q.an_en && !link_up))
		else $error("power saving entered without its conditions");

	a_psave_blocks: assert property (
		state_q == ppmc_pkg::ST_PSAVE |->
		!pwr.rx_on && pwr.tx_on && pwr.ed_on && pwr.pll_on)
		else $error("wrong blocks powered in power saving");

	a_psave_reset_off: assert property (
		$past(!aresetn) |-> !ctl_q.psave && ctl_q.sense_n)
		else $error("low-power enable set after reset");

	a_sleep_pll_off: assert property (
		state_q == ppmc_pkg::ST_SLEEP && ctl_q.plloff |->
		!pwr.pll_on && pwr.tx_on && pwr.ed_on)
		else $error("pll left on in sense sleep");

	a_pulse_only_sleep: assert property (
		link_pulse |-> $past(state_q == ppmc_pkg::ST_SLEEP))
		else $error("link pulse outside sense sleep");

	a_sleep_needs_en: assert property (
		$rose(state_q == ppmc_pkg::ST_SLEEP) |-> $past(!ctl_q.sense_n))
		else $error("sense sleep without its enable");

	a_pdown_halts: assert property (
		state_q == ppmc_pkg::ST_PDOWN |-> pwr == ppmc_pkg::ppmc_pwr_t'(5'h00))
		else $error("blocks still powered in power-down");

	a_pdown_exit: assert property (
		s_pdn_cleared and !srst |=> state_q != ppmc_pkg::ST_PDOWN)
		else $error("power-down not left after clear");

	a_slow_clock: assert property (
		wr_afe && w_strb_q[0] && w_data_q[`PPMC_B_SLOW] |=> slow_osc_sel && !crystal_input_en)
		else $error("crystal input still selected");

	a_lowest_power: assert property (
		lowest_power |-> pwr == ppmc_pkg::ppmc_pwr_t'(5'h00))
		else $error("lowest power with blocks on");

	a_soft_reset_back: assert property (
		srst |=> ctl_q == ppmc_pkg::PPMC_CTL_RST && state_q == ppmc_pkg::ST_NORMAL
		##0 soft_reset)
		else $error("soft reset did not restore defaults");

	a_energy_wake: assert property (
		s_sleep_energy and !srst |=> s_all_up)
		else $error("energy seen but blocks not woken");

endmodule : ppmc_power_ctl

// File: ppmc_line_model.sv
// ppmc_line_model: far end of the cable, reports energy and link
// assumes plugged and partner_awake come from the bench, synchronous to aclk
`timescale 1ns/100ps
module ppmc_line_model #(
	parameter int unsigned LINK_DLY = 6
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// cable state
	input  wire logic plugged,
	input  wire logic partner_awake,
	// line status
	output logic      link_up,
	output logic      energy_detect
);
	logic [7:0] cnt_q;
	// a sleeping partner gives energy on the wire but never a link
	always_ff @(posedge aclk) begin
		if (!aresetn || !plugged || !partner_awake) cnt_q <= 8'h00;
		else if (cnt_q != LINK_DLY[7:0]) cnt_q <= cnt_q + 8'h01;
	end
	always_ff @(posedge aclk) energy_detect <= aresetn && plugged;
	assign link_up = plugged && partner_awake && (cnt_q == LINK_DLY[7:0]);
endmodule : ppmc_line_model

// File: ppmc_power_ctl_tb.sv
// ppmc_power_ctl_tb: self-checking bench for the power controller
// assumes short gap and wake parameters so each test runs briefly
`timescale 1ns/100ps
`include "ppmc_consts.svh"
module ppmc_power_ctl_tb;
	localparam int unsigned GAP_S = 20;
	localparam int unsigned GAP_L = 40;
	localparam int unsigned WAKE  = 10;
	localparam int          LIMIT = 5000;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, link_up, energy_detect, plugged, awake;
	logic crystal_input_en, slow_osc_sel, lowest_power, link_pulse, soft_reset;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	ppmc_pkg::ppmc_pwr_t pwr;
	int errors, total_checks, cyc, pulse_cnt, sr_cnt;

	ppmc_power_ctl #(.GAP_SHORT_CYC(GAP_S), .GAP_LONG_CYC(GAP_L), .WAKE_CYC(WAKE))
	ppmc_power_ctl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link_up(link_up), .energy_detect(energy_detect),
		.pwr(pwr), .crystal_input_en(crystal_input_en), .slow_osc_sel(slow_osc_sel),
		.lowest_power(lowest_power), .link_pulse(link_pulse), .soft_reset(soft_reset));
	ppmc_line_model ppmc_line_model_i (.aclk(aclk), .aresetn(aresetn), .plugged(plugged),
		.partner_awake(awake), .link_up(link_up), .energy_detect(energy_detect));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// hang guard: every test is short, so a few thousand cycles is plenty
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (link_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
		if (soft_reset === 1'b1) sr_cnt <= sr_cnt + 1;
		if (cyc == LIMIT) begin
			errors = errors + 1;
			$display("Error at %0t: timeout", $time);
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_val

	function automatic logic [7:0] ba(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction : ba

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	// starts one edge late so no signal is driven twice in one time step
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_read

	task automatic reg_wr(input logic [5:0] idx, input logic [31:0] d);
		logic [1:0] r;
		axi_write(ba(idx), d, r);
		check_val({30'h0, r}, {30'h0, `PPMC_RESP_OKAY}, "write response");
		tick(3);
	endtask : reg_wr

	task automatic reg_chk(input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(ba(idx), d, r);
		check_val({30'h0, r}, {30'h0, `PPMC_RESP_OKAY}, "read response");
		check_val(d, exp, "read data");
	endtask : reg_chk

	task automatic chk_pwr(input logic [4:0] exp);
		check_val({27'h0, pwr}, {27'h0, exp}, "power enables");
	endtask : chk_pwr

	task automatic chk_clk(input logic [2:0] exp);
		check_val({29'h0, crystal_input_en, slow_osc_sel, lowest_power}, {29'h0, exp}, "clocking");
	endtask : chk_clk

	// syncs on one pulse, then measures the next interval
	task automatic wait_gap(input int exp);
		int c0, p0;
		p0 = pulse_cnt;
		do @(posedge aclk); while (pulse_cnt == p0);
		c0 = cyc;
		p0 = pulse_cnt;
		do @(posedge aclk); while (pulse_cnt == p0);
		check_val(cyc - c0, exp, "pulse gap");
	endtask : wait_gap

	task automatic test_defaults();
		chk_pwr(5'h1F);
		chk_clk(3'h4);
		reg_chk(`PPMC_IDX_XCTL, 32'h0000_0800);
		reg_chk(`PPMC_IDX_PCTL2, 32'h0000_0000);
		$display("test_defaults done");
	endtask : test_defaults

	task automatic test_psave();
		reg_wr(`PPMC_IDX_PCTL2, 32'h0000_0400);
		chk_pwr(5'h17);
		plugged <= 1'b1;
		awake <= 1'b1;
		tick(12);
		chk_pwr(5'h1F);
		plugged <= 1'b0;
		tick(3);
		chk_pwr(5'h17);
		reg_wr(`PPMC_IDX_PCTL2, 32'h0000_0000);
		chk_pwr(5'h1F);
		$display("test_psave done");
	endtask : test_psave

	task automatic test_sleep();
		int p0;
		reg_wr(`PPMC_IDX_XCTL, 32'h0000_0000);
		chk_pwr(5'h17);
		wait_gap(GAP_S);
		reg_wr(`PPMC_IDX_OWN, 32'h0000_0001);
		wait_gap(GAP_L);
		reg_wr(`PPMC_IDX_OWN, 32'h0000_0000);
		reg_wr(`PPMC_IDX_DRC, 32'h0000_0010);
		chk_pwr(5'h13);
		// partner asleep: energy only, no link
		plugged <= 1'b1;
		awake <= 1'b0;
		tick(3);
		chk_pwr(5'h1F);
		plugged <= 1'b0;
		tick(WAKE + 5);
		chk_pwr(5'h13);
		plugged <= 1'b1;
		awake <= 1'b1;
		tick(12);
		chk_pwr(5'h1F);
		p0 = pulse_cnt;
		tick(2 * GAP_L);
		check_val(pulse_cnt - p0, 0, "pulses with link");
		plugged <= 1'b0;
		awake <= 1'b0;
		tick(3);
		chk_pwr(5'h13);
		reg_wr(`PPMC_IDX_BCTL, 32'h0000_0000);
		chk_pwr(5'h1F);
		reg_wr(`PPMC_IDX_BCTL, 32'h0000_1000);
		reg_wr(`PPMC_IDX_XCTL, 32'h0000_0800);
		reg_wr(`PPMC_IDX_DRC, 32'h0000_0000);
		chk_pwr(5'h1F);
		$display("test_sleep done");
	endtask : test_sleep

	task automatic test_pdown();
		int s0;
		reg_wr(`PPMC_IDX_BCTL, 32'h0000_1800);
		chk_pwr(5'h00);
		reg_wr(`PPMC_IDX_AFE, 32'h0000_0020);
		chk_clk(3'h3);
		reg_chk(`PPMC_IDX_BCTL, 32'h0000_1800);
		reg_wr(`PPMC_IDX_AFE, 32'h0000_0000);
		chk_clk(3'h4);
		chk_pwr(5'h00);
		reg_wr(`PPMC_IDX_BCTL, 32'h0000_1000);
		chk_pwr(5'h1F);
		reg_wr(`PPMC_IDX_PCTL2, 32'h0000_0400);
		s0 = sr_cnt;
		reg_wr(`PPMC_IDX_BCTL, 32'h0000_9000);
		tick(2);
		check_val(sr_cnt - s0, 1, "soft reset pulses");
		chk_pwr(5'h1F);
		reg_chk(`PPMC_IDX_PCTL2, 32'h0000_0000);
		reg_chk(`PPMC_IDX_BCTL, 32'h0000_1000);
		$display("test_pdown done");
	endtask : test_pdown

	task automatic test_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		axi_write(8'h08, 32'hFFFF_FFFF, r);
		check_val({30'h0, r}, {30'h0, `PPMC_RESP_SLVERR}, "unmapped write");
		axi_read(8'h08, d, r);
		check_val({30'h0, r}, {30'h0, `PPMC_RESP_SLVERR}, "unmapped read");
		check_val(d, 32'h0000_0000, "unmapped data");
		chk_pwr(5'h1F);
		$display("test_unmapped done");
	endtask : test_unmapped

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		plugged = 1'b0;
		awake = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_defaults();
		test_psave();
		test_sleep();
		test_pdown();
		test_unmapped();
		stop_test();
	end
endmodule : ppmc_power_ctl_tb
